// ---- rtl/gpio_pkg.sv ----
// Shared constants for the general-purpose I/O port logic.
// Assumes one port of up to GPIO_WIDTH pins on a single clock.
package gpio_pkg;

    localparam int          GPIO_WIDTH        = 8;
    localparam logic        GPIO_DIR_INPUT    = 1'b0;
    localparam logic        GPIO_DIR_OUTPUT   = 1'b1;
    localparam logic [7:0]  GPIO_DIR_RESET    = 8'h00;
    localparam logic [7:0]  GPIO_LATCH_RESET  = 8'h00;
    localparam logic [7:0]  GPIO_SAMPLE_RESET = 8'h00;
    localparam logic [7:0]  GPIO_RDATA_RESET  = 8'h00;

    typedef enum logic [1:0] {
        GPIO_RD_NONE,
        GPIO_RD_DIRECTION,
        GPIO_RD_LATCH,
        GPIO_RD_PAD
    } gpio_read_sel_t;

endpackage : gpio_pkg

// ---- rtl/gpio_port.sv ----
// One general-purpose I/O port: direction, output latch, pad sample,
// pull-up and sleep input clamp per pin, with alternate-function overrides.
// Assumes strobes are one-cycle pulses from logic on i_clk; pad is external.
//
// Behaviour
// - Output direction drives pad to the output latch level.
// - Writing one to input-sample bit inverts the output latch bit.
// - Without pull-up override, input pull-up only with latch one and global disable clear.
// - Global pull-up disable turns off every pull-up not under pull-up override.
// - Pad level readable via input-sample in both directions, synchronised.
// - Sync stage transparent while clock high, registered at next rise.
// - External pad change reaches sample after half to one and a half periods.
// - Pad value written at a rising edge appears one period later.
// - Sleep clamp forces digital input to ground in deep sleep.
// - Clamp bypassed for enabled external interrupt pins and overridden pins.
// - Releasing clamp on high pin gives a rising edge to interrupt logic.
// - Pull-ups disabled during reset.
// - Direction, value, pull-up and input enable accept per-pin overrides.
// - Strobes shared per port; clock, clamp, pull-up disable shared globally.
// - Pull-up override enable selects override value for pull-up.
// - Direction override enable selects override value for driver enable.
// - Value override when driving; else latch, inverted by toggle override.
// - Input-enable override selects override value over sleep state.
module gpio_port #(
    parameter int WIDTH = gpio_pkg::GPIO_WIDTH
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_wdata,
    input  wire logic             i_direction_write_strobe,
    input  wire logic             i_output_latch_write_strobe,
    input  wire logic             i_input_register_write_strobe,
    input  wire logic             i_direction_read_strobe,
    input  wire logic             i_output_latch_read_strobe,
    input  wire logic             i_pad_read_strobe,
    output logic      [WIDTH-1:0] o_rdata,
    input  wire logic             i_global_pullup_disable,
    input  wire logic             i_sleep_clamp,
    input  wire logic [WIDTH-1:0] i_ext_int_enable,
    input  wire logic [WIDTH-1:0] i_pullup_override_enable,
    input  wire logic [WIDTH-1:0] i_pullup_override_value,
    input  wire logic [WIDTH-1:0] i_direction_override_enable,
    input  wire logic [WIDTH-1:0] i_direction_override_value,
    input  wire logic [WIDTH-1:0] i_value_override_enable,
    input  wire logic [WIDTH-1:0] i_value_override_value,
    input  wire logic [WIDTH-1:0] i_toggle_override_enable,
    input  wire logic [WIDTH-1:0] i_input_enable_override_enable,
    input  wire logic [WIDTH-1:0] i_input_enable_override_value,
    input  wire logic [WIDTH-1:0] i_pad_in,
    output logic      [WIDTH-1:0] o_pad_out,
    output logic      [WIDTH-1:0] o_pad_oe,
    output logic      [WIDTH-1:0] o_pullup_en,
    output logic      [WIDTH-1:0] o_alt_function_digital_input,
    output logic      [WIDTH-1:0] o_pin_direction_bit,
    output logic      [WIDTH-1:0] o_pin_output_latch,
    output logic      [WIDTH-1:0] o_pin_input_sample
);
    import gpio_pkg::*;

    logic [WIDTH-1:0] pin_direction_register_bit_r;
    logic [WIDTH-1:0] pin_output_latch_r;
    logic [WIDTH-1:0] pin_input_sample;
    logic [WIDTH-1:0] input_enable;
    logic [WIDTH-1:0] digital_in;
    gpio_read_sel_t   read_sel;

    ////////////////////////////////////////////////////////////////////////
    // Registers; one set of strobes serves all pins of the port.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pin_direction_register_bit_r <= WIDTH'(GPIO_DIR_RESET);
        end else if (i_direction_write_strobe) begin
            pin_direction_register_bit_r <= i_wdata;
        end
    end

    // A plain write wins over a same-cycle toggle write
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pin_output_latch_r <= WIDTH'(GPIO_LATCH_RESET);
        end else if (i_output_latch_write_strobe) begin
            pin_output_latch_r <= i_wdata;
        end else if (i_input_register_write_strobe) begin
            pin_output_latch_r <= pin_output_latch_r ^ i_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-pin pad control with alternate-function overrides.
    genvar n;
    generate
        for (n = 0; n < WIDTH; n++) begin : g_pin
            always_comb begin
                o_pad_oe[n] = i_direction_override_enable[n]
                            ? i_direction_override_value[n]
                            : (pin_direction_register_bit_r[n] == GPIO_DIR_OUTPUT);
                o_pad_out[n] = (o_pad_oe[n] && i_value_override_enable[n])
                             ? i_value_override_value[n]
                             : (pin_output_latch_r[n] ^ i_toggle_override_enable[n]);
                // reset kills pull-ups before any clock runs
                if (i_reset) begin
                    o_pullup_en[n] = 1'b0;
                end else if (i_pullup_override_enable[n]) begin
                    o_pullup_en[n] = i_pullup_override_value[n];
                end else begin
                    o_pullup_en[n] = (pin_direction_register_bit_r[n] == GPIO_DIR_INPUT)
                                   && pin_output_latch_r[n]
                                   && !i_global_pullup_disable;
                end
                input_enable[n] = i_input_enable_override_enable[n]
                                ? i_input_enable_override_value[n]
                                : (!i_sleep_clamp || i_ext_int_enable[n]);
                // Clamp to ground; release yields an edge on a high pin.
                digital_in[n] = i_pad_in[n] && input_enable[n];
            end
        end
    endgenerate

    // Unsynchronised; alternate functions bring their own synchroniser
    assign o_alt_function_digital_input = digital_in;

    ////////////////////////////////////////////////////////////////////////
    // Pad read path, whatever the direction.
    gpio_sync #(
        .WIDTH (WIDTH)
    ) u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_d     (digital_in),
        .o_q     (pin_input_sample)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read-back; one strobe at a time is expected, pad read has priority
    always_comb begin
        if (i_pad_read_strobe) begin
            read_sel = GPIO_RD_PAD;
        end else if (i_output_latch_read_strobe) begin
            read_sel = GPIO_RD_LATCH;
        end else if (i_direction_read_strobe) begin
            read_sel = GPIO_RD_DIRECTION;
        end else begin
            read_sel = GPIO_RD_NONE;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= WIDTH'(GPIO_RDATA_RESET);
        end else begin
            case (read_sel)
                GPIO_RD_PAD:       o_rdata <= pin_input_sample;
                GPIO_RD_LATCH:     o_rdata <= pin_output_latch_r;
                GPIO_RD_DIRECTION: o_rdata <= pin_direction_register_bit_r;
                GPIO_RD_NONE:      o_rdata <= o_rdata;
                default:           o_rdata <= o_rdata;
            endcase
        end
    end

    assign o_pin_direction_bit = pin_direction_register_bit_r;
    assign o_pin_output_latch  = pin_output_latch_r;
    assign o_pin_input_sample  = pin_input_sample;

endmodule : gpio_port

// ---- rtl/gpio_sync.sv ----
// Pad synchroniser: falling-edge capture stage then rising-edge register.
// Assumes the pad input is asynchronous to i_clk.
module gpio_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);
    import gpio_pkg::*;

    logic [WIDTH-1:0] hold_r;

    ////////////////////////////////////////////////////////////////////////
    // Stage one holds the value present when the clock falls, which is the
    // latch that is open while the clock is high. A flop is used instead of a
    // real latch to keep timing analysis simple; the sampled value is equal.
    always_ff @(negedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            hold_r <= '0;
        end else begin
            hold_r <= i_d;
        end
    end

    // Stage two loads at the next rising edge
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_q <= '0;
        end else begin
            o_q <= hold_r;
        end
    end

endmodule : gpio_sync

// ---- testbench/gpio_pad_model.sv ----
// Board side of the port pins: external drivers, pull-ups, floating pins.
// Assumes the board drives a pin only where i_ext_en is set.
module gpio_pad_model #(
    parameter int WIDTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic [WIDTH-1:0] i_pad_out,
    input  wire logic [WIDTH-1:0] i_pad_oe,
    input  wire logic [WIDTH-1:0] i_pullup_en,
    input  wire logic [WIDTH-1:0] i_ext_val,
    input  wire logic [WIDTH-1:0] i_ext_en,
    output logic      [WIDTH-1:0] o_pad
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [WIDTH-1:0] float_r = '0;
    // Unheld pins wander, so a stale level never passes as a match
    always_ff @(negedge i_clk) float_r <= ~float_r;
    assign o_pad = (i_pad_oe & i_pad_out) | (~i_pad_oe & i_ext_en & i_ext_val)
                 | (~i_pad_oe & ~i_ext_en & (i_pullup_en | float_r));
endmodule : gpio_pad_model

// ---- testbench/gpio_port_bench.sv ----
// Bench for gpio_port: strobe tasks and sequenced checks against a pad model.
// Assumes the checker is bound in; strobes are one-cycle pulses.
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
module gpio_port_bench;
    import gpio_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic       i_clk = 1'b0, i_reset = 1'b1, gpd = 1'b0, clamp = 1'b0;
    logic [2:0] ws = '0, rs = '0;
    logic [7:0] wdata = '0, ext_val = '0, ext_en = '0, ov [10] = '{default: '0};
    logic [7:0] pad, rdata, pout, poe, pup, alt, dir, lat, smp;
    int         fail_count = 0, samples_checked = 0;
    always #10 i_clk = ~i_clk;
    gpio_port #(.WIDTH(8)) i_gpio_port (.i_clk(i_clk), .i_reset(i_reset), .i_wdata(wdata),
        .i_direction_write_strobe(ws[0]), .i_output_latch_write_strobe(ws[1]),
        .i_input_register_write_strobe(ws[2]), .i_direction_read_strobe(rs[0]),
        .i_output_latch_read_strobe(rs[1]), .i_pad_read_strobe(rs[2]), .o_rdata(rdata),
        .i_global_pullup_disable(gpd), .i_sleep_clamp(clamp), .i_ext_int_enable(ov[9]),
        .i_pullup_override_enable(ov[0]), .i_pullup_override_value(ov[1]),
        .i_direction_override_enable(ov[2]), .i_direction_override_value(ov[3]),
        .i_value_override_enable(ov[4]), .i_value_override_value(ov[5]),
        .i_toggle_override_enable(ov[6]), .i_input_enable_override_enable(ov[7]),
        .i_input_enable_override_value(ov[8]), .i_pad_in(pad), .o_pad_out(pout),
        .o_pad_oe(poe), .o_pullup_en(pup), .o_alt_function_digital_input(alt),
        .o_pin_direction_bit(dir), .o_pin_output_latch(lat), .o_pin_input_sample(smp));
    gpio_pad_model #(.WIDTH(8)) i_gpio_pad_model (.i_clk(i_clk), .i_pad_out(pout),
        .i_pad_oe(poe), .i_pullup_en(pup), .i_ext_val(ext_val), .i_ext_en(ext_en),
        .o_pad(pad));
    ////////////////////////////////////////////////////////////////////
    task automatic wr(input int s, input logic [7:0] d);
        wdata <= d;
        ws[s] <= 1'b1;
        @(negedge i_clk);
        ws <= '0;
        @(negedge i_clk);
    endtask : wr
    // Non-blocking drive: the sync stage also samples on the falling edge
    task automatic rd(input int s, input logic [7:0] e, input string n);
        rs[s] <= 1'b1;
        @(negedge i_clk);
        rs <= '0;
        `CHK(n, e, rdata)
        @(negedge i_clk);
    endtask : rd
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(negedge i_clk);
        i_reset <= 1'b0;
        `CHK("dir", GPIO_DIR_RESET, dir)
        `CHK("oe", 8'h00, poe | lat)
        wr(1, 8'hFF);
        rd(2, 8'hFF, "pulled pad");
        gpd <= 1'b1;
        @(negedge i_clk);
        `CHK("pull-up off", 8'h00, pup)
        gpd <= 1'b0;
        wr(0, 8'hFF);
        `CHK("out high", 8'hFF, pout & poe)
        wr(2, 8'h3C);
        rd(1, 8'hC3, "toggled");
        wr(2, 8'h00);
        rd(1, 8'hC3, "kept");
        wr(1, 8'h5A);
        `CHK("sample", 8'h5A, smp)
        rd(2, 8'h5A, "readback");
        rd(0, 8'hFF, "dir read");
        $display("drive test done");
        wr(1, 8'h0F);
        wr(0, 8'h00);
        ext_en <= 8'hF0;
        ext_val <= 8'h90;
        repeat (2) @(negedge i_clk);
        `CHK("ext sample", 8'h9F, smp)
        clamp <= 1'b1;
        ov[9] <= 8'h0C;
        repeat (2) @(negedge i_clk);
        `CHK("clamped", 8'h0C, smp)
        ov[7] <= 8'hFF;
        ov[8] <= 8'hFF;
        @(negedge i_clk);
        `CHK("input ovr", 8'h9F, alt)
        ov[7] <= 8'h00;
        clamp <= 1'b0;
        repeat (2) @(negedge i_clk);
        `CHK("unclamped", 8'h9F, smp)
        $display("input test done");
        ov[0] <= 8'hF0;
        ov[1] <= 8'h81;
        ov[2] <= 8'hFF;
        ov[3] <= 8'h55;
        ov[4] <= 8'h0F;
        ov[5] <= 8'h03;
        @(negedge i_clk);
        `CHK("oe ovr", 8'h55, poe)
        `CHK("value ovr", 8'h01, pout & poe)
        `CHK("pull-up ovr", 8'h8F, pup)
        ov[4] <= 8'h00;
        ov[6] <= 8'hFF;
        @(negedge i_clk);
        `CHK("toggle ovr", 8'h50, pout & poe)
        ov[0] <= 8'hFF;
        ov[1] <= 8'hFF;
        i_reset <= 1'b1;
        @(negedge i_clk);
        `CHK("reset pull-up", 8'h00, pup)
        i_reset <= 1'b0;
        $display("override test done");
        tally_and_finish();
    end
    // Whole sequence takes about 43 cycles; this leaves a wide margin
    initial begin
        #50us;
        fail_count++;
        tally_and_finish();
    end
endmodule : gpio_port_bench

// ---- testbench/gpio_port_chk.sv ----
// Assertions on gpio_port pins and registers, bound into every port.
// Assumes the bench changes inputs on the falling edge of i_clk.
module gpio_port_chk #(
    parameter int WIDTH = 8
) (
    input wire logic             i_clk,
    input wire logic             i_reset,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic             i_direction_write_strobe,
    input wire logic             i_output_latch_write_strobe,
    input wire logic             i_input_register_write_strobe,
    input wire logic             i_global_pullup_disable,
    input wire logic             i_sleep_clamp,
    input wire logic [WIDTH-1:0] i_pullup_override_enable,
    input wire logic [WIDTH-1:0] i_pullup_override_value,
    input wire logic [WIDTH-1:0] i_direction_override_enable,
    input wire logic [WIDTH-1:0] i_direction_override_value,
    input wire logic [WIDTH-1:0] i_value_override_enable,
    input wire logic [WIDTH-1:0] i_toggle_override_enable,
    input wire logic [WIDTH-1:0] i_pad_in,
    input wire logic [WIDTH-1:0] o_pad_out,
    input wire logic [WIDTH-1:0] o_pad_oe,
    input wire logic [WIDTH-1:0] o_pullup_en,
    input wire logic [WIDTH-1:0] o_pin_direction_bit,
    input wire logic [WIDTH-1:0] o_pin_output_latch,
    input wire logic [WIDTH-1:0] o_pin_input_sample
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [WIDTH-1:0] pad_n_r;
    // Mirror of the falling-edge capture, so timing is checked exactly
    always_ff @(negedge i_clk) pad_n_r <= i_pad_in;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////////////////////////////////
    dir_write_a: assert property (i_direction_write_strobe |=>
        o_pin_direction_bit == $past(i_wdata)) else $error("dir write lost");
    latch_write_a: assert property (i_output_latch_write_strobe |=>
        o_pin_output_latch == $past(i_wdata)) else $error("latch write lost");
    latch_toggle_a: assert property (i_input_register_write_strobe
        && !i_output_latch_write_strobe |=> o_pin_output_latch ==
        ($past(o_pin_output_latch) ^ $past(i_wdata))) else $error("bad toggle");
    latch_hold_a: assert property (!i_input_register_write_strobe
        && !i_output_latch_write_strobe |=> $stable(o_pin_output_latch))
        else $error("latch moved");
    pad_level_a: assert property (((o_pad_out ^ o_pin_output_latch) & o_pad_oe
        & ~(i_value_override_enable | i_toggle_override_enable)) == '0)
        else $error("pad level wrong");
    drive_enable_a: assert property (o_pad_oe ==
        ((i_direction_override_enable & i_direction_override_value)
        | (~i_direction_override_enable & o_pin_direction_bit))) else $error("oe wrong");
    pullup_rule_a: assert property (o_pullup_en ==
        ((i_pullup_override_enable & i_pullup_override_value)
        | (~i_pullup_override_enable & ~o_pin_direction_bit & o_pin_output_latch
        & {WIDTH{!i_global_pullup_disable}}))) else $error("pull-up wrong");
    sample_sync_a: assert property (!i_sleep_clamp [*2] |=>
        o_pin_input_sample == $past(pad_n_r)) else $error("sample late");
    cover property (i_input_register_write_strobe);
    cover property (i_sleep_clamp ##1 !i_sleep_clamp);
    cover property ((|i_direction_override_enable) && (|o_pad_oe));
endmodule : gpio_port_chk
bind gpio_port gpio_port_chk #(.WIDTH(WIDTH)) i_gpio_port_chk (.*);
